// ==== rtl/emb_bus_ctrl.sv ====
`include "emb_defs.svh"
module emb_bus_ctrl #(
  parameter bit HAS_BUS = 1'b1
) (
  input  logic        clk_sys_in,
  input  logic        nrst_in,
  input  logic [3:0]  avs_address_in,
  input  logic        avs_read_in,
  input  logic        avs_write_in,
  input  logic [31:0] avs_writedata_in,
  input  logic [3:0]  avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic        avs_waitrequest_out,
  input  logic        cfg_data_width_sel_in,
  input  logic [1:0]  cfg_addr_width_sel_in,
  input  logic        cfg_wait_enable_in,
  input  logic        exec_external_in,
  input  logic        sleep_in,
  input  logic        req_valid_in,
  input  logic [1:0]  req_kind_in,
  input  logic [20:0] req_addr_in,
  input  logic [7:0]  req_table_latch_in,
  output logic        req_ready_out,
  output logic        rsp_valid_out,
  output logic [15:0] rsp_data_out,
  input  logic [27:0] gpio_out_in,
  input  logic [27:0] gpio_oe_n_in,
  output logic [27:0] gpio_in_out,
  input  logic [27:0] pad_in,
  output logic [27:0] pad_out,
  output logic [27:0] pad_oe_n_out
);

  logic [1:0]          rst_sync_q;
  logic                rst_n;
  logic                cfg_done_q;
  logic                data16_q;
  logic [1:0]          aw_q;
  logic                wait_en_q;
  logic [7:0]          ctrl_q;
  logic                ebd_eff_q;
  logic [27:0]         pad_sync;
  emb_pkg::emb_state_t state_q;
  logic [1:0]          op_q;
  logic [20:0]         addr_q;
  logic [7:0]          wdata_q;
  logic [7:0]          hold_lo_q;
  logic                take;
  logic                word_even;
  logic                bus_mode;
  logic                owned;
  logic                is_wr;
  logic                ctr_last;
  logic [3:0]          len;
  logic [19:0]         lmask;
  logic [19:0]         dmask;
  logic [19:0]         bus_addr;
  logic [19:0]         wr_word;
  logic [15:0]         rd_word;
  logic [7:0]          ctl;
  logic [27:0]         pad_d;
  logic [27:0]         oe_d;
  logic [7:0]          status;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  emb_sync2 #(.W(`EMB_PADS)) u_pad_sync (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n),
    .d_in     (pad_in),
    .q_out    (pad_sync)
  );

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      gpio_in_out <= 28'h0000000;
    end else begin
      gpio_in_out <= pad_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration word, caught once after reset release

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_done_q <= 1'b0;
      data16_q   <= 1'b1;
      aw_q       <= `EMB_AW_MCU;
      wait_en_q  <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_done_q <= 1'b1;
      data16_q   <= cfg_data_width_sel_in;
      aw_q       <= cfg_addr_width_sel_in;
      wait_en_q  <= cfg_wait_enable_in;
    end
  end

  function automatic logic [19:0] emb_width_mask(input logic [1:0] aw);
    unique case (aw)
      `EMB_AW_20: emb_width_mask = `EMB_MASK_20;
      `EMB_AW_16: emb_width_mask = `EMB_MASK_16;
      `EMB_AW_12: emb_width_mask = `EMB_MASK_12;
      default:    emb_width_mask = 20'h00000;
    endcase
  endfunction

  // Inverted stall code is the wait count
  function automatic logic [3:0] emb_len(input logic rd, input logic wt,
                                         input logic [1:0] stall);
    logic [1:0] waits;
    waits   = wt ? ~stall : 2'h0;
    emb_len = (rd ? `EMB_RD_SETTLE : `EMB_WR_SETTLE) + {2'h0, waits};
  endfunction

  // Lines beyond the address width never join the bus
  // Width code 01 leaves lines 16-19 to the ports
  assign lmask    = emb_width_mask(aw_q);
  // Data confined to lines inside the address width
  assign dmask    = (data16_q ? `EMB_DMASK_16 : `EMB_DMASK_8) & lmask;
  assign bus_mode = HAS_BUS && cfg_done_q && (aw_q != `EMB_AW_MCU);

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    end
  end

  assign status = {sleep_in, wait_en_q, aw_q, data16_q, ebd_eff_q, owned,
                   (state_q != emb_pkg::EMB_IDLE)};

  // Absent bus option reads as zero
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      avs_readdata_out <= 32'h00000000;
      if (avs_address_in == `EMB_REG_CTRL && HAS_BUS) begin
        avs_readdata_out[7:0] <= ctrl_q & `EMB_CTRL_RMASK;
      end else if (avs_address_in == `EMB_REG_STAT) begin
        avs_readdata_out[7:0] <= status;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `EMB_CTRL_RST;
    end else if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
                 && avs_address_in == `EMB_REG_CTRL && bus_mode) begin
      ctrl_q <= avs_writedata_in[7:0] & `EMB_CTRL_RMASK;
    end
  end

  // Disable takes hold only while executing internally
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ebd_eff_q <= 1'b0;
    end else if (!exec_external_in) begin
      ebd_eff_q <= ctrl_q[`EMB_EBD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer

  assign take      = req_valid_in && req_ready_out;
  assign word_even = (req_kind_in == emb_pkg::EMB_TWR) && data16_q
                     && ctrl_q[`EMB_WM_HI] && !req_addr_in[0];
  assign is_wr     = (op_q == emb_pkg::EMB_TWR);
  // Waits only for table operations with wait enable
  assign len       = emb_len(req_kind_in != emb_pkg::EMB_TWR,
                             wait_en_q && (req_kind_in != emb_pkg::EMB_FETCH),
                             ctrl_q[`EMB_WAIT_HI:`EMB_WAIT_LO]);

  emb_wait_ctr #(.W(4)) u_wait_ctr (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n),
    .load_in  (take),
    .dec_in   (state_q == emb_pkg::EMB_DATA),
    .count_in (len),
    .last_out (ctr_last)
  );

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      req_ready_out <= 1'b0;
    end else if (take) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= (state_q == emb_pkg::EMB_IDLE) && bus_mode && !sleep_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      op_q    <= 2'h0;
      addr_q  <= 21'h000000;
      wdata_q <= 8'h00;
    end else if (take) begin
      op_q    <= req_kind_in;
      addr_q  <= req_addr_in;
      wdata_q <= req_table_latch_in;
    end
  end

  // Even byte in word mode only fills the low half; the odd byte writes the word
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      hold_lo_q <= 8'h00;
    end else if (take && word_even) begin
      hold_lo_q <= req_table_latch_in;
    end
  end

  assign rd_word = !data16_q ? {8'h00, pad_sync[7:0]} :
                   (op_q == emb_pkg::EMB_TRD) ?
                   {8'h00, addr_q[0] ? pad_sync[15:8] : pad_sync[7:0]} :
                   pad_sync[15:0] & dmask[15:0];

  // Address phase always comes before data
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= emb_pkg::EMB_IDLE;
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= 16'h0000;
    end else begin
      rsp_valid_out <= 1'b0;
      unique case (state_q)
        emb_pkg::EMB_IDLE: begin
          if (take && word_even) begin
            rsp_valid_out <= 1'b1;
          end else if (take) begin
            state_q <= emb_pkg::EMB_ADDR;
          end
        end
        emb_pkg::EMB_ADDR: begin
          state_q <= emb_pkg::EMB_DATA;
        end
        emb_pkg::EMB_DATA: begin
          if (ctr_last) begin
            state_q <= emb_pkg::EMB_END;
          end
        end
        emb_pkg::EMB_END: begin
          state_q       <= emb_pkg::EMB_IDLE;
          rsp_valid_out <= 1'b1;
          rsp_data_out  <= is_wr ? 16'h0000 : rd_word;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership and drive

  // Cleared disable keeps the bus on the pins
  // Set disable yields pins except during an access
  assign owned    = bus_mode && (!ebd_eff_q || state_q != emb_pkg::EMB_IDLE);
  // Word address on 16-bit bus, byte lsb travels separately
  assign bus_addr = data16_q ? addr_q[20:1] : addr_q[19:0];
  assign wr_word  = (data16_q && ctrl_q[`EMB_WM_HI]) ? {4'h0, wdata_q, hold_lo_q}
                                                    : {4'h0, wdata_q, wdata_q};

  always_comb begin
    ctl = `EMB_CTL_IDLE;
    if (state_q == emb_pkg::EMB_ADDR) begin
      ctl[`EMB_C_ALE] = 1'b1;
    end
    if (state_q == emb_pkg::EMB_ADDR || state_q == emb_pkg::EMB_DATA) begin
      // Select active per access, forced high in sleep
      ctl[`EMB_C_CE]  = sleep_in;
      ctl[`EMB_C_BA0] = addr_q[0];
    end
    if (state_q == emb_pkg::EMB_DATA && !is_wr) begin
      ctl[`EMB_C_OE] = 1'b0;
      ctl[`EMB_C_LB] = !data16_q;
      ctl[`EMB_C_UB] = !data16_q;
    end else if (state_q == emb_pkg::EMB_DATA) begin
      // Narrow bus ignores the wide write mode
      if (!data16_q) begin
        ctl[`EMB_C_WRL] = 1'b0;
      end else if (ctrl_q[`EMB_WM_HI]) begin
        ctl[`EMB_C_WRH] = 1'b0;
      end else if (ctrl_q[`EMB_WM_HI:`EMB_WM_LO] == `EMB_WM_BYTE_SEL) begin
        ctl[`EMB_C_WRH] = 1'b0;
        ctl[`EMB_C_UB]  = !addr_q[0];
        ctl[`EMB_C_LB]  = addr_q[0];
      // Byte write: one strobe for the addressed byte
      end else begin
        ctl[`EMB_C_WRH] = !addr_q[0];
        ctl[`EMB_C_WRL] = addr_q[0];
      end
    end
  end

  // Shared lines turn from address to data
  // Idle bus floats its lines, strobes parked
  always_comb begin
    pad_d = gpio_out_in;
    oe_d  = gpio_oe_n_in;
    if (owned) begin
      for (int i = 0; i < `EMB_LINES; i++) begin
        if (lmask[i]) begin
          pad_d[i] = bus_addr[i];
          oe_d[i]  = 1'b1;
          if (state_q == emb_pkg::EMB_ADDR) begin
            oe_d[i] = 1'b0;
          end else if (state_q == emb_pkg::EMB_DATA) begin
            if (!dmask[i]) begin
              oe_d[i] = 1'b0;
            end else if (is_wr) begin
              pad_d[i] = wr_word[i];
              oe_d[i]  = 1'b0;
            end
          end
        end
      end
      pad_d[`EMB_PADS-1:`EMB_CTL_BASE] = ctl;
      oe_d[`EMB_PADS-1:`EMB_CTL_BASE]  = 8'h00;
    end
  end

  // Registered drive of all 28 pins
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pad_out      <= 28'h0000000;
      pad_oe_n_out <= 28'hFFFFFFF;
    end else begin
      pad_out      <= pad_d;
      pad_oe_n_out <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] dcnt_q;
  logic [3:0] len_q;

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      dcnt_q <= 4'h0;
      len_q  <= 4'h0;
    end else begin
      if (take) begin
        len_q <= len;
      end
      if (state_q == emb_pkg::EMB_ADDR) begin
        dcnt_q <= 4'h0;
      end else if (state_q == emb_pkg::EMB_DATA) begin
        dcnt_q <= dcnt_q + 4'h1;
      end
    end
  end

  chk_mcu_nowrite: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    (cfg_done_q && aw_q == `EMB_AW_MCU) |=> $stable(ctrl_q))
    else $error("control register changed in microcontroller mode");

  chk_data_len: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    (state_q == emb_pkg::EMB_END) |-> (dcnt_q == len_q))
    else $error("data phase length does not match wait count");

  chk_zero_wait: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    (state_q == emb_pkg::EMB_ADDR && is_wr && wait_en_q
     && ctrl_q[`EMB_WAIT_HI:`EMB_WAIT_LO] == 2'h3)
    |=> (state_q == emb_pkg::EMB_DATA) ##1 (state_q == emb_pkg::EMB_END))
    else $error("zero-wait table write not one data cycle");

  chk_addr_first: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    (state_q == emb_pkg::EMB_DATA) |->
    ($past(state_q) == emb_pkg::EMB_ADDR || $past(state_q) == emb_pkg::EMB_DATA))
    else $error("data phase without address phase");

  chk_idle_pins: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    ($past(owned) && $past(state_q) == emb_pkg::EMB_IDLE) |->
    (pad_out[`EMB_CTL_BASE+`EMB_C_CE] && !pad_out[`EMB_CTL_BASE+`EMB_C_ALE]
     && !pad_out[`EMB_CTL_BASE+`EMB_C_BA0] && pad_oe_n_out[0]))
    else $error("idle bus pins not parked");

  chk_sleep_ce: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    ($past(sleep_in) && $past(owned)) |-> pad_out[`EMB_CTL_BASE+`EMB_C_CE])
    else $error("chip select active during sleep");

  chk_defer_ebd: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    $changed(ebd_eff_q) |-> !$past(exec_external_in))
    else $error("disable applied while executing externally");

  chk_high_free: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    (cfg_done_q && aw_q == `EMB_AW_16) |=>
    (pad_oe_n_out[19:16] == $past(gpio_oe_n_in[19:16])))
    else $error("upper address lines taken in 16-bit mode");

  chk_one_strobe: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    ($past(state_q) == emb_pkg::EMB_DATA && $past(is_wr) && $past(data16_q)
     && $past(ctrl_q[`EMB_WM_HI:`EMB_WM_LO]) == 2'h0) |->
    (pad_out[`EMB_CTL_BASE+`EMB_C_WRH] != pad_out[`EMB_CTL_BASE+`EMB_C_WRL]))
    else $error("byte write mode strobes not exclusive");

  chk_absent_zero: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n)
    (!HAS_BUS && avs_read_in && avs_address_in == `EMB_REG_CTRL
     && avs_waitrequest_out) |=> (avs_readdata_out == 32'h00000000))
    else $error("absent control register reads nonzero");

endmodule

// ==== rtl/emb_defs.svh ====
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH

// Register byte offsets
`define EMB_REG_CTRL      4'h0
`define EMB_REG_STAT      4'h4

// Bus control register layout
`define EMB_CTRL_RST      8'h00
`define EMB_CTRL_RMASK    8'hB3
`define EMB_EBD_BIT       7
`define EMB_WAIT_HI       5
`define EMB_WAIT_LO       4
`define EMB_WM_HI         1
`define EMB_WM_LO         0
`define EMB_WM_BYTE_SEL   2'h1

// Address width select codes
`define EMB_AW_20         2'h0
`define EMB_AW_16         2'h1
`define EMB_AW_12         2'h2
`define EMB_AW_MCU        2'h3
`define EMB_MASK_20       20'hFFFFF
`define EMB_MASK_16       20'h0FFFF
`define EMB_MASK_12       20'h00FFF
`define EMB_DMASK_16      20'h0FFFF
`define EMB_DMASK_8       20'h000FF

// Pin layout: lines 0..19, control port above them
`define EMB_LINES         20
`define EMB_PADS          28
`define EMB_CTL_BASE      20
`define EMB_C_ALE         0
`define EMB_C_OE          1
`define EMB_C_WRL         2
`define EMB_C_WRH         3
`define EMB_C_BA0         4
`define EMB_C_CE          5
`define EMB_C_LB          6
`define EMB_C_UB          7
`define EMB_CTL_IDLE      8'hEE

// Data phase lengths in instruction cycles before wait states
`define EMB_RD_SETTLE     4'h3
`define EMB_WR_SETTLE     4'h1

`endif

// ==== rtl/emb_pkg.sv ====
package emb_pkg;
  typedef enum logic [1:0] {
    EMB_IDLE = 2'b00,
    EMB_ADDR = 2'b01,
    EMB_DATA = 2'b10,
    EMB_END  = 2'b11
  } emb_state_t;

  typedef enum logic [1:0] {
    EMB_FETCH = 2'b00,
    EMB_TRD   = 2'b01,
    EMB_TWR   = 2'b10
  } emb_op_t;
endpackage

// ==== rtl/emb_sync2.sv ====
module emb_sync2 #(
  parameter int W = 28
) (
  input  logic         clk_in,
  input  logic         rst_n_in,
  input  logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// ==== rtl/emb_wait_ctr.sv ====
module emb_wait_ctr #(
  parameter int W = 4
) (
  input  logic         clk_in,
  input  logic         rst_n_in,
  input  logic         load_in,
  input  logic         dec_in,
  input  logic [W-1:0] count_in,
  output logic         last_out
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
    end else if (load_in) begin
      cnt_q <= count_in;
    end else if (dec_in && (cnt_q != '0)) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign last_out = (cnt_q == W'(1));
endmodule

// ==== verif/emb_bus_ctrl_bench.sv ====
module emb_bus_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [3:0]  av_addr = 4'h0;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [3:0]  av_be = 4'hF;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        cfg_dw = 1'b1;
  logic [1:0]  cfg_aw = 2'h0;
  logic        sleep = 1'b0;
  logic        exec_ext = 1'b0;
  logic        req_valid = 1'b0;
  logic [1:0]  req_kind = 2'h0;
  logic [20:0] req_addr = 21'h0;
  logic [7:0]  req_tl = 8'h00;
  logic        req_ready_out;
  logic        rsp_valid_out;
  logic [15:0] rsp_data_out;
  logic [27:0] gpio_out = 28'h0;
  logic [27:0] gpio_oe_n = 28'h0;
  logic [27:0] pad_in;
  logic [27:0] pad_out;
  logic [27:0] pad_oe_n_out;
  logic [19:0] line_drive;
  logic [19:0] lat_addr;
  logic [15:0] wr_data;
  logic [3:0]  wr_str;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          seed = 54;
  always #5 clk_sys_in = ~clk_sys_in;
  // Wire level: whoever drives wins, else the model or a toggling level
  assign pad_in[19:0]  = (~pad_oe_n_out[19:0] & pad_out[19:0]) | (pad_oe_n_out[19:0] & line_drive);
  assign pad_in[27:20] = pad_out[27:20] ^ pad_oe_n_out[27:20];
  emb_bus_ctrl dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .avs_address_in(av_addr),
    .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata),
    .avs_byteenable_in(av_be), .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait),
    .cfg_data_width_sel_in(cfg_dw), .cfg_addr_width_sel_in(cfg_aw), .cfg_wait_enable_in(1'b1),
    .exec_external_in(exec_ext), .sleep_in(sleep), .req_valid_in(req_valid),
    .req_kind_in(req_kind), .req_addr_in(req_addr), .req_table_latch_in(req_tl),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .gpio_out_in(gpio_out), .gpio_oe_n_in(gpio_oe_n), .gpio_in_out(), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n_out(pad_oe_n_out));
  emb_mem_model mem (.clk_in(clk_sys_in), .pad_out_in(pad_out), .line_drive_out(line_drive),
    .lat_addr_out(lat_addr), .wr_data_out(wr_data), .wr_str_out(wr_str));
  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int t;
    av_addr <= a;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= ~wr;
    t = 0;
    do begin
      @(posedge clk_sys_in);
      t++;
    end while (av_wait !== 1'b0 && t < 50);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic req(input logic [1:0] k, input logic [20:0] a, input logic [7:0] tl,
                     output int n);
    int t;
    req_kind <= k;
    req_addr <= a;
    req_tl <= tl;
    req_valid <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys_in);
      t++;
    end while (req_ready_out !== 1'b1 && t < 100);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (rsp_valid_out !== 1'b1 && n < 100);
  endtask
  function automatic logic [15:0] word_at(input logic [19:0] ln);
    return {ln[7:0] ^ 8'h5A, ln[15:8] ^ 8'hC3};
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
  initial begin
    logic [31:0] q;
    logic [20:0] a;
    logic [7:0]  tl;
    logic [15:0] w;
    logic        dis;
    int          n;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    av(1'b0, 4'h0, 32'h0, q); check("ctrl reset", q, 32'h0);
    av(1'b0, 4'h8, 32'h0, q); check("unmapped", q, 32'h0);
    av(1'b0, 4'h4, 32'h0, q); check("width status", q[5:3], 3'h1);
    av_be <= 4'hE;
    av(1'b1, 4'h0, 32'hFF, q);
    av_be <= 4'hF;
    av(1'b0, 4'h0, 32'h0, q); check("lane off", q, 32'h0);
    for (int i = 0; i < 16; i++) begin
      dis = $random(seed);
      gpio_out <= $random(seed);
      gpio_oe_n <= $random(seed);
      av(1'b1, 4'h0, {dis, 1'b0, i[1:0], 2'b00, i[3:2]}, q);
      av(1'b0, 4'h0, 32'h0, q); check("ctrl rb", q, {dis, 1'b0, i[1:0], 2'b00, i[3:2]});
      a = $random(seed);
      tl = $random(seed);
      if (i[3]) begin
        req(2'h2, {a[20:1], 1'b0}, tl, n);
        a[0] = 1'b1;
        w = {req_tl ^ 8'h3C, tl};
        tl = tl ^ 8'h3C;
      end else begin
        w = {tl, tl};
      end
      req(2'h2, a, tl, n); check("write lat", n, 4 + 3 - i[1:0]);
      check("latched", lat_addr, a[20:1]);
      check("wr data", wr_data, w);
      check("wr strobe", wr_str[1:0], (i[3:2] == 0 && !a[0]) ? 2'b01 : 2'b10);
      if (i[3:2] == 2'h1) check("byte sel", wr_str[3:2], a[0] ? 2'b10 : 2'b01);
      a = $random(seed);
      w = word_at(a[20:1]);
      req(2'h1, a, 8'h00, n); check("read lat", n, 6 + 3 - i[1:0]);
      check("rd byte", rsp_data_out[7:0], a[0] ? w[15:8] : w[7:0]);
      req(2'h0, a, 8'h00, n); check("fetch", {n[7:0], rsp_data_out}, {8'd6, w});
      repeat (3) @(posedge clk_sys_in);
      if (dis) check("port lines", pad_oe_n_out[19:0], gpio_oe_n[19:0]);
      else check("idle pins", {pad_out[27:20], pad_oe_n_out[19:0]}, {8'hEE, 20'hFFFFF});
      $display("test %0d done", i);
    end
    av(1'b1, 4'h0, 32'h00, q);
    repeat (2) @(posedge clk_sys_in);
    exec_ext <= 1'b1;
    av(1'b1, 4'h0, 32'h80, q);
    repeat (2) @(posedge clk_sys_in);
    av(1'b0, 4'h4, 32'h0, q); check("defer held", q[2], 1'b0);
    exec_ext <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    av(1'b0, 4'h4, 32'h0, q); check("defer done", q[2], 1'b1);
    $display("test defer done");
    sleep <= 1'b1;
    av(1'b1, 4'h0, 32'h00, q);
    repeat (3) @(posedge clk_sys_in);
    check("sleep", {req_ready_out, pad_out[25]}, 2'b01);
    sleep <= 1'b0;
    nrst_in <= 1'b0;
    cfg_aw <= 2'h3;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    av(1'b1, 4'h0, 32'hB3, q);
    av(1'b0, 4'h0, 32'h0, q); check("mcu ctrl", q, 32'h0);
    check("mcu ready", req_ready_out, 1'b0);
    $display("test mode done");
    nrst_in <= 1'b0;
    cfg_aw <= 2'h1;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    gpio_oe_n <= 28'h00A0000;
    req(2'h1, 21'h0ABCD, 8'h00, n); check("aw16 rd", rsp_data_out[7:0], 8'hBC);
    check("aw16 free", pad_oe_n_out[19:16], 4'hA);
    $display("test aw16 done");
    print_verdict();
  end
endmodule

// ==== verif/emb_mem_model.sv ====
module emb_mem_model (
  input  wire logic [0:0]  clk_in,
  input  wire logic [27:0] pad_out_in,
  output logic      [19:0] line_drive_out,
  output logic      [19:0] lat_addr_out,
  output logic      [15:0] wr_data_out,
  output logic      [3:0]  wr_str_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] idle_q = 20'h00000;
  ////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    // Released lines must not look held
    idle_q <= ~idle_q;
    if (pad_out_in[20]) begin
      lat_addr_out <= pad_out_in[19:0];
    end
    if (!pad_out_in[22] || !pad_out_in[23]) begin
      wr_data_out <= pad_out_in[15:0];
      wr_str_out  <= ~{pad_out_in[27:26], pad_out_in[23:22]};
    end
  end
  // word driven while output strobe low
  always_comb begin
    line_drive_out = pad_out_in[21] ? idle_q :
      {idle_q[19:16], lat_addr_out[7:0] ^ 8'h5A, lat_addr_out[15:8] ^ 8'hC3};
  end
endmodule
